// ===== logic/crt_pkg.sv
// Constants shared by the capture/reload up/down timer
package crt_pkg;
	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'hc8;
	localparam logic [7:0] IDX_AUX_MODE_CONTROL = 8'hc9;
	localparam logic [7:0] IDX_RELOAD_CAPTURE_LOW = 8'hca;
	localparam logic [7:0] IDX_RELOAD_CAPTURE_HIGH = 8'hcb;
	localparam logic [7:0] IDX_TIMER_COUNT_LOW = 8'hcc;
	localparam logic [7:0] IDX_TIMER_COUNT_HIGH = 8'hcd;
	// ---------------------------------------------------------------
	// Field positions of timer_control
	// ---------------------------------------------------------------
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_EXTERNAL_FLAG = 6;
	localparam int BIT_RX_CLOCK_SELECT = 5;
	localparam int BIT_TX_CLOCK_SELECT = 4;
	localparam int BIT_EXTERNAL_EVENT_ENABLE = 3;
	localparam int BIT_RUN_CONTROL = 2;
	localparam int BIT_COUNTER_SELECT = 1;
	localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
	// ---------------------------------------------------------------
	// Field positions of aux_mode_control
	// ---------------------------------------------------------------
	localparam int BIT_CLOCK_OUT_ENABLE = 1;
	localparam int BIT_DOWN_COUNT_ENABLE = 0;
	// ---------------------------------------------------------------
	// Reset values and fixed count values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] RST_AUX_MODE_CONTROL = 8'h00;
	localparam logic [7:0] RST_RELOAD_CAPTURE = 8'h00;
	localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	// ---------------------------------------------------------------
	// Timing: system clock cycles per machine cycle
	// ---------------------------------------------------------------
	localparam int MACHINE_CYCLE_CLOCKS = 12;
endpackage : crt_pkg

// ===== logic/crt_sync_fall.sv
// Two-stage synchroniser with falling-edge detector for a pin input
`timescale 1ns/1ps
module crt_sync_fall (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level,
	output logic fall
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// Meta stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Edge seen once per 1-to-0 step; source must hold each level long enough
	assign level = sync_ff;
	assign fall = prev_ff & ~sync_ff;
endmodule : crt_sync_fall

// ===== logic/crt_tick_div.sv
// Divider producing a one-cycle machine-cycle enable pulse
`timescale 1ns/1ps
module crt_tick_div #(
	parameter int DIV = crt_pkg::MACHINE_CYCLE_CLOCKS
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	logic [7:0] cnt_ff;

	// Count up and pulse on wrap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 8'h00;
			tick <= 1'b0;
		end else if (cnt_ff == 8'(DIV - 1)) begin
			cnt_ff <= 8'h00;
			tick <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule : crt_tick_div

// ===== logic/crt_timer.sv
// Capture/reload up/down 16-bit timer with AHB-Lite register slave
// Overview of operation
// - counter_select 1 counts external input falling edges, 0 counts machine cycles.
// - overflow_flag set on overflow, sticky; never set while a serial clock select is 1.
// - external_flag set when a trigger falling edge causes capture or reload.
// - Enabled interrupt requested by either flag; external_flag ignored when down counting enabled.
// - Receive baud pulse from own overflow if rx_clock_select, else other timer.
// - Transmit baud pulse from own overflow if tx_clock_select, else other timer.
// - Trigger edges act only with external_event_enable and no baud generation.
// - Counting only while run_control is 1; otherwise the block is off.
// - capture_reload_select picks capture or reload; baud generation forces reload.
// - Mode decode: off, baud, capture, up-only reload, up/down reload.
// - Capture mode is a free-running 16-bit timer setting overflow_flag on overflow.
// - Capture mode trigger edge copies count into reload/capture pair, sets external_flag.
// - down_count_enable resets to 0, so reload mode counts up.
// - Up-only reload: overflow at all-ones sets overflow_flag and loads reload pair.
// - Up-only reload: trigger edge also reloads and sets external_flag.
// - Up/down mode: trigger level 1 counts up, 0 counts down; overflow reloads.
// - Counting down, count equal to reload pair underflows, loads all-ones, sets flag.
// - Up/down mode toggles external_flag on every overflow and underflow.
// - clock_out_enable drives clock pin toggling on every overflow.
`timescale 1ns/1ps
module crt_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic ext_trigger_in,
	input wire logic ext_count_in,
	input wire logic other_timer_ovf,
	input wire logic serial_mode_var,
	input wire logic timer_irq_en,
	output logic timer_irq,
	output logic rx_baud_pulse,
	output logic tx_baud_pulse,
	output logic clock_out_pin,
	output logic clock_out_oe
);
	// ---------------------------------------------------------------
	// Register decode helper
	// ---------------------------------------------------------------
	// One-hot select: 0 ctrl, 1 aux, 2 rcap low, 3 rcap high, 4 count low, 5 count high
	function automatic logic [5:0] crt_sel(input logic [7:0] idx);
		logic [5:0] s;
		s = 6'h00;
		case (idx)
			crt_pkg::IDX_TIMER_CONTROL: s = 6'h01;
			crt_pkg::IDX_AUX_MODE_CONTROL: s = 6'h02;
			crt_pkg::IDX_RELOAD_CAPTURE_LOW: s = 6'h04;
			crt_pkg::IDX_RELOAD_CAPTURE_HIGH: s = 6'h08;
			crt_pkg::IDX_TIMER_COUNT_LOW: s = 6'h10;
			crt_pkg::IDX_TIMER_COUNT_HIGH: s = 6'h20;
			default: s = 6'h00;
		endcase
		return s;
	endfunction : crt_sel

	logic [7:0] ctrl_ff;
	logic [1:0] aux_ff;
	logic [15:0] rcap_ff;
	logic [15:0] count_ff;
	logic dp_wr_ff;
	logic [7:0] dp_idx_ff;
	logic mc_tick;
	logic cnt_level;
	logic cnt_fall;
	logic trig_level;
	logic trig_fall;

	// ---------------------------------------------------------------
	// Pin synchronisers and machine-cycle divider
	// ---------------------------------------------------------------
	crt_tick_div #(.DIV(crt_pkg::MACHINE_CYCLE_CLOCKS)) u_div (
		.clk(hclk),
		.rst_n(hresetn),
		.tick(mc_tick)
	);

	crt_sync_fall u_cnt_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.pin_in(ext_count_in),
		.level(cnt_level),
		.fall(cnt_fall)
	);

	crt_sync_fall u_trig_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.pin_in(ext_trigger_in),
		.level(trig_level),
		.fall(trig_fall)
	);

	// ---------------------------------------------------------------
	// AHB-Lite slave: address phase capture, zero wait states
	// ---------------------------------------------------------------
	logic take;
	logic [7:0] a_idx;
	logic [5:0] wsel;
	logic [7:0] wbyte;
	logic wr_cnt;
	logic wr_ctrl;

	assign take = hsel & hready & htrans[1];
	assign a_idx = haddr[9:2];
	assign wsel = dp_wr_ff ? crt_sel(dp_idx_ff) : 6'h00;
	assign wbyte = hwdata[7:0];
	assign wr_cnt = wsel[4] | wsel[5];
	assign wr_ctrl = wsel[0];

	// Latch write address phase for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_ff <= 1'b0;
			dp_idx_ff <= 8'h00;
		end else if (hready) begin
			dp_wr_ff <= take & hwrite & (haddr[31:10] == 22'h000000);
			dp_idx_ff <= a_idx;
		end
	end

	// Read data snapshot, bypassing a write finishing in the same cycle
	logic [5:0] rsel;
	logic [7:0] rd_val;
	assign rsel = (haddr[31:10] == 22'h000000) ? crt_sel(a_idx) : 6'h00;
	always_comb begin
		rd_val = 8'h00;
		if (rsel[0])
			rd_val = ctrl_ff;
		if (rsel[1])
			rd_val = {6'h00, aux_ff};
		if (rsel[2])
			rd_val = rcap_ff[7:0];
		if (rsel[3])
			rd_val = rcap_ff[15:8];
		if (rsel[4])
			rd_val = count_ff[7:0];
		if (rsel[5])
			rd_val = count_ff[15:8];
		if (dp_wr_ff && (dp_idx_ff == a_idx) && (rsel != 6'h00))
			rd_val = rsel[1] ? {6'h00, wbyte[1:0]} : wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take && !hwrite)
				hrdata <= {24'h000000, rd_val};
		end
	end

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	logic run;
	logic baud;
	logic capture;
	logic updown;
	logic dir_up;
	logic tick;
	logic at_top;
	logic at_bot;
	logic ovf;
	logic unf;
	logic wrap;
	logic trig_ev;

	assign run = ctrl_ff[crt_pkg::BIT_RUN_CONTROL];
	assign baud = ctrl_ff[crt_pkg::BIT_RX_CLOCK_SELECT] | ctrl_ff[crt_pkg::BIT_TX_CLOCK_SELECT];
	assign capture = ~baud & ctrl_ff[crt_pkg::BIT_CAPTURE_RELOAD_SELECT];
	assign updown = ~baud & ~ctrl_ff[crt_pkg::BIT_CAPTURE_RELOAD_SELECT] & aux_ff[crt_pkg::BIT_DOWN_COUNT_ENABLE];
	assign dir_up = ~updown | trig_level;
	// Count source: machine cycle or external edge
	assign tick = run & (ctrl_ff[crt_pkg::BIT_COUNTER_SELECT] ? cnt_fall : mc_tick);
	assign at_top = count_ff == crt_pkg::COUNT_ALL_ONES;
	assign at_bot = count_ff == rcap_ff;
	assign ovf = tick & dir_up & at_top;
	assign unf = tick & ~dir_up & at_bot;
	assign wrap = ovf | unf;
	// Trigger edge acts only outside baud generation and up/down mode
	assign trig_ev = run & ctrl_ff[crt_pkg::BIT_EXTERNAL_EVENT_ENABLE] & ~baud & ~updown & trig_fall;

	// ---------------------------------------------------------------
	// Count and reload/capture registers
	// ---------------------------------------------------------------
	logic [15:0] nxt_count;
	logic [15:0] nxt_rcap;
	always_comb begin
		nxt_count = count_ff;
		if (tick) begin
			if (dir_up) begin
				if (!at_top)
					nxt_count = count_ff + 16'h0001;
				else if (capture)
					nxt_count = crt_pkg::COUNT_ZERO;
				else
					nxt_count = rcap_ff;
			end else if (at_bot) begin
				nxt_count = crt_pkg::COUNT_ALL_ONES;
			end else begin
				nxt_count = count_ff - 16'h0001;
			end
		end
		if (trig_ev && !capture)
			nxt_count = rcap_ff;
		if (wsel[4])
			nxt_count[7:0] = wbyte;
		if (wsel[5])
			nxt_count[15:8] = wbyte;
	end

	always_comb begin
		nxt_rcap = rcap_ff;
		if (trig_ev && capture)
			nxt_rcap = count_ff;
		if (wsel[2])
			nxt_rcap[7:0] = wbyte;
		if (wsel[3])
			nxt_rcap[15:8] = wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= {crt_pkg::RST_TIMER_COUNT, crt_pkg::RST_TIMER_COUNT};
			rcap_ff <= {crt_pkg::RST_RELOAD_CAPTURE, crt_pkg::RST_RELOAD_CAPTURE};
		end else begin
			count_ff <= nxt_count;
			rcap_ff <= nxt_rcap;
		end
	end

	// ---------------------------------------------------------------
	// Control registers and sticky flags (hardware set wins over clear)
	// ---------------------------------------------------------------
	logic [7:0] nxt_ctrl;
	logic tf_set;
	logic exf_set;
	logic exf_tgl;
	assign tf_set = wrap & ~baud;
	assign exf_set = trig_ev;
	assign exf_tgl = updown & wrap;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl)
			nxt_ctrl = wbyte;
		nxt_ctrl[crt_pkg::BIT_OVERFLOW_FLAG] = nxt_ctrl[crt_pkg::BIT_OVERFLOW_FLAG] | tf_set;
		nxt_ctrl[crt_pkg::BIT_EXTERNAL_FLAG] = (nxt_ctrl[crt_pkg::BIT_EXTERNAL_FLAG] ^ exf_tgl) | exf_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= crt_pkg::RST_TIMER_CONTROL;
			aux_ff <= crt_pkg::RST_AUX_MODE_CONTROL[1:0];
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wsel[1])
				aux_ff <= wbyte[1:0];
		end
	end

	// ---------------------------------------------------------------
	// Interrupt request, baud pulses and clock output
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= timer_irq_en & (ctrl_ff[crt_pkg::BIT_OVERFLOW_FLAG] |
				(ctrl_ff[crt_pkg::BIT_EXTERNAL_FLAG] & ~aux_ff[crt_pkg::BIT_DOWN_COUNT_ENABLE]));
		end
	end

	// Select serial clock sources in variable-rate serial modes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_baud_pulse <= 1'b0;
			tx_baud_pulse <= 1'b0;
		end else begin
			rx_baud_pulse <= serial_mode_var &
				(ctrl_ff[crt_pkg::BIT_RX_CLOCK_SELECT] ? ovf : other_timer_ovf);
			tx_baud_pulse <= serial_mode_var &
				(ctrl_ff[crt_pkg::BIT_TX_CLOCK_SELECT] ? ovf : other_timer_ovf);
		end
	end

	// Square wave at half the overflow rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_out_pin <= 1'b0;
			clock_out_oe <= 1'b0;
		end else begin
			clock_out_oe <= aux_ff[crt_pkg::BIT_CLOCK_OUT_ENABLE];
			if (wrap)
				clock_out_pin <= ~clock_out_pin;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	AST_TF_ON_OVF: assert property (@(posedge hclk) disable iff (!hresetn)
		tf_set |=> ctrl_ff[crt_pkg::BIT_OVERFLOW_FLAG])
		else $error("overflow flag not set after overflow");
	AST_TF_NOT_BAUD: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ctrl_ff[crt_pkg::BIT_OVERFLOW_FLAG]) |-> $past(!baud || wr_ctrl))
		else $error("overflow flag rose during baud generation");
	AST_EXF_ON_TRIG: assert property (@(posedge hclk) disable iff (!hresetn)
		exf_set |=> ctrl_ff[crt_pkg::BIT_EXTERNAL_FLAG])
		else $error("external flag not set after trigger event");
	AST_IRQ_UPDOWN: assert property (@(posedge hclk) disable iff (!hresetn)
		(aux_ff[crt_pkg::BIT_DOWN_COUNT_ENABLE] && !ctrl_ff[crt_pkg::BIT_OVERFLOW_FLAG]) |=> !timer_irq)
		else $error("external flag raised interrupt with down counting enabled");
	AST_OFF_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
		(!run && !wr_cnt) |=> $stable(count_ff))
		else $error("count moved while stopped");
	AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
		(trig_ev && capture && !wsel[2] && !wsel[3]) |=> (rcap_ff == $past(count_ff)))
		else $error("capture did not copy count");
	AST_RELOAD_UP: assert property (@(posedge hclk) disable iff (!hresetn)
		(ovf && !capture && !wr_cnt) |=> (count_ff == $past(rcap_ff)))
		else $error("overflow did not reload count");
	AST_UNDERFLOW: assert property (@(posedge hclk) disable iff (!hresetn)
		(unf && !trig_ev && !wr_cnt) |=> (count_ff == crt_pkg::COUNT_ALL_ONES))
		else $error("underflow did not load all ones");
	AST_EXF_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
		(exf_tgl && !wr_ctrl) |=> (ctrl_ff[crt_pkg::BIT_EXTERNAL_FLAG] != $past(ctrl_ff[crt_pkg::BIT_EXTERNAL_FLAG])))
		else $error("external flag did not toggle");
	AST_CLKOUT: assert property (@(posedge hclk) disable iff (!hresetn)
		wrap |=> (clock_out_pin != $past(clock_out_pin)))
		else $error("clock output did not toggle on overflow");
	AST_TIMER_RATE: assert property (@(posedge hclk) disable iff (!hresetn)
		(run && !ctrl_ff[crt_pkg::BIT_COUNTER_SELECT] && !at_top && dir_up && !trig_ev && !wr_cnt && mc_tick)
		|=> (count_ff == $past(count_ff) + 16'h0001))
		else $error("timer did not advance on machine cycle");
	AST_WRITE_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
		wsel[4] |=> (count_ff[7:0] == $past(hwdata[7:0])))
		else $error("count write lost to hardware update");
endmodule : crt_timer

// ===== sim/crt_pins_model.sv
// Pin-side partner model: trigger pin, count pin and the other timer's overflow
`timescale 1ns/1ps
module crt_pins_model (
	input wire logic hclk,
	output logic trig_pin,
	output logic count_pin,
	output logic ovf_pulse
);
	// ---------------------------------------------------------------
	// Idle levels
	// ---------------------------------------------------------------
	initial begin
		trig_pin = 1'b1;
		count_pin = 1'b1;
		ovf_pulse = 1'b0;
	end
	// ---------------------------------------------------------------
	// Level drivers
	// ---------------------------------------------------------------
	// Each level is held longer than one machine cycle
	task automatic hold();
		repeat (16) @(posedge hclk);
	endtask : hold
	// Trigger pin level: edge source and count direction
	task automatic set_trig(input logic lv);
		trig_pin <= lv;
		hold();
	endtask : set_trig
	// Whole low-high pulses on the count pin
	task automatic count_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			count_pin <= 1'b0;
			hold();
			count_pin <= 1'b1;
			hold();
		end
	endtask : count_pulses
	// One-cycle overflow pulse of the other timer
	task automatic pulse_ovf();
		ovf_pulse <= 1'b1;
		@(posedge hclk);
		ovf_pulse <= 1'b0;
		@(posedge hclk);
	endtask : pulse_ovf
endmodule : crt_pins_model

// ===== sim/crt_timer_tb_top.sv
// Self-checking testbench of the capture/reload up/down timer
`timescale 1ns/1ps
module crt_timer_tb_top;
	logic hclk, hresetn, hsel, hwrite, serial_mode_var, timer_irq_en;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic hreadyout, hresp, timer_irq, rx_baud_pulse, tx_baud_pulse, clock_out_pin, clock_out_oe;
	logic [31:0] hrdata;
	logic trig_pin, count_pin, ovf_pulse;
	logic [7:0] tmp;
	logic [21:0] hi_addr;
	int errors, num_checks, cyc, rx_cnt, tx_cnt;
	// ---------------------------------------------------------------
	// Clock, partner and design
	// ---------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	crt_pins_model u_pins (.hclk(hclk), .trig_pin(trig_pin), .count_pin(count_pin), .ovf_pulse(ovf_pulse));
	crt_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .ext_trigger_in(trig_pin), .ext_count_in(count_pin),
		.other_timer_ovf(ovf_pulse), .serial_mode_var(serial_mode_var), .timer_irq_en(timer_irq_en),
		.timer_irq(timer_irq), .rx_baud_pulse(rx_baud_pulse), .tx_baud_pulse(tx_baud_pulse),
		.clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe));
	// ---------------------------------------------------------------
	// Baud pulse counters and hang guard
	// ---------------------------------------------------------------
	always @(posedge hclk) begin
		cyc++;
		if (rx_baud_pulse === 1'b1) rx_cnt++;
		if (tx_baud_pulse === 1'b1) tx_cnt++;
		if (cyc == 20000) begin
			errors++;
			$display("MISMATCH t=%0t run took too long", $time);
			end_of_test();
		end
	end
	// ---------------------------------------------------------------
	// Bus and compare tasks
	// ---------------------------------------------------------------
	// One AHB-Lite single transfer; waits for hready in both phases
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
		haddr <= {hi_addr, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {wd, wd, wd, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask : bus
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		bus(idx, 1'b1, d, r);
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] r;
		bus(idx, 1'b0, 8'h00, r);
		chk(r, exp);
	endtask : rdc
	// Loads count and reload pairs while the timer is stopped
	task automatic load(input logic [15:0] cnt, input logic [15:0] rc);
		wr(crt_pkg::IDX_TIMER_COUNT_LOW, cnt[7:0]);
		wr(crt_pkg::IDX_TIMER_COUNT_HIGH, cnt[15:8]);
		wr(crt_pkg::IDX_RELOAD_CAPTURE_LOW, rc[7:0]);
		wr(crt_pkg::IDX_RELOAD_CAPTURE_HIGH, rc[15:8]);
	endtask : load
	task automatic chk_cnt(input logic [15:0] exp);
		rdc(crt_pkg::IDX_TIMER_COUNT_LOW, exp[7:0]);
		rdc(crt_pkg::IDX_TIMER_COUNT_HIGH, exp[15:8]);
	endtask : chk_cnt
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		serial_mode_var = 1'b0;
		timer_irq_en = 1'b1;
		hi_addr = 22'h000000;
		errors = 0;
		num_checks = 0;
		cyc = 0;
		rx_cnt = 0;
		tx_cnt = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values, down counting off, unmapped place reads zero
		for (int i = 0; i < 6; i++) rdc(8'hc8 + i[7:0], 8'h00);
		wr(8'hce, 8'h5a);
		rdc(8'hce, 8'h00);
		chk({7'h0, hresp}, 8'h00);
		// Address above the register window: write ignored, read gives zero
		hi_addr = 22'h000001;
		wr(crt_pkg::IDX_TIMER_COUNT_LOW, 8'h77);
		rdc(crt_pkg::IDX_TIMER_COUNT_LOW, 8'h00);
		hi_addr = 22'h000000;
		rdc(crt_pkg::IDX_TIMER_COUNT_LOW, 8'h00);
		// Up-only reload on overflow in timer function
		wr(crt_pkg::IDX_AUX_MODE_CONTROL, 8'h02);
		repeat (2) @(posedge hclk);
		chk({7'h0, clock_out_oe}, 8'h01);
		load(16'hfffe, 16'h1234);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h04);
		repeat (30) @(posedge hclk);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'h84);
		chk({7'h0, timer_irq}, 8'h01);
		// Interrupt enable low masks a set flag
		timer_irq_en <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({7'h0, timer_irq}, 8'h00);
		timer_irq_en <= 1'b1;
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h00);
		rdc(crt_pkg::IDX_TIMER_COUNT_HIGH, 8'h12);
		bus(crt_pkg::IDX_TIMER_COUNT_LOW, 1'b0, 8'h00, tmp);
		chk({7'h0, tmp >= 8'h34 && tmp <= 8'h36}, 8'h01);
		chk({7'h0, clock_out_pin}, 8'h01);
		chk({7'h0, timer_irq}, 8'h00);
		// Exactly 120 clocks of run give ten machine cycles
		load(16'h0000, 16'h1234);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h04);
		repeat (118) @(posedge hclk);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h00);
		chk_cnt(16'h000a);
		repeat (50) @(posedge hclk);
		chk_cnt(16'h000a);
		// Baud generation: no overflow flag, trigger ignored, forced reload
		wr(crt_pkg::IDX_AUX_MODE_CONTROL, 8'h00);
		serial_mode_var <= 1'b1;
		load(16'hfffe, 16'hfff0);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h1d);
		rx_cnt = 0;
		tx_cnt = 0;
		u_pins.pulse_ovf();
		u_pins.pulse_ovf();
		u_pins.set_trig(1'b0);
		u_pins.set_trig(1'b1);
		repeat (200) @(posedge hclk);
		chk(rx_cnt[7:0], 8'h02);
		chk({7'h0, tx_cnt > 0}, 8'h01);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'h1d);
		rdc(crt_pkg::IDX_TIMER_COUNT_HIGH, 8'hff);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h3d);
		rx_cnt = 0;
		tx_cnt = 0;
		u_pins.pulse_ovf();
		repeat (300) @(posedge hclk);
		chk({7'h0, tx_cnt > 0}, 8'h01);
		chk(rx_cnt[7:0], tx_cnt[7:0]);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h00);
		serial_mode_var <= 1'b0;
		// Capture in counter function, edge ignored until enabled
		load(16'hffff, 16'haa55);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h07);
		u_pins.count_pulses(1);
		chk_cnt(16'h0000);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'h87);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h07);
		u_pins.count_pulses(5);
		chk_cnt(16'h0005);
		u_pins.set_trig(1'b0);
		u_pins.set_trig(1'b1);
		rdc(crt_pkg::IDX_RELOAD_CAPTURE_LOW, 8'h55);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h0f);
		u_pins.set_trig(1'b0);
		u_pins.set_trig(1'b1);
		rdc(crt_pkg::IDX_RELOAD_CAPTURE_LOW, 8'h05);
		rdc(crt_pkg::IDX_RELOAD_CAPTURE_HIGH, 8'h00);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'h4f);
		chk({7'h0, timer_irq}, 8'h01);
		// Up-only reload caused by a trigger edge
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h00);
		load(16'h0007, 16'h4321);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h0e);
		u_pins.set_trig(1'b0);
		u_pins.set_trig(1'b1);
		chk_cnt(16'h4321);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'h4e);
		// Up/down reload: underflow at reload value, overflow back up
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h00);
		wr(crt_pkg::IDX_AUX_MODE_CONTROL, 8'h01);
		load(16'h0004, 16'h0003);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h06);
		u_pins.set_trig(1'b0);
		u_pins.count_pulses(1);
		chk_cnt(16'h0003);
		u_pins.count_pulses(1);
		chk_cnt(16'hffff);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'hc6);
		wr(crt_pkg::IDX_TIMER_CONTROL, 8'h46);
		repeat (4) @(posedge hclk);
		chk({7'h0, timer_irq}, 8'h00);
		u_pins.set_trig(1'b1);
		u_pins.count_pulses(1);
		chk_cnt(16'h0003);
		rdc(crt_pkg::IDX_TIMER_CONTROL, 8'h86);
		end_of_test();
	end
endmodule : crt_timer_tb_top
